// File: edge_sync.v
// Two-flop synchroniser with rising-edge detection for one pin-level input.
module edge_sync (
    // Clock and reset
    input wire clk_in,
    input wire rst_in,
    // Asynchronous input and synchronised results
    input wire async_in,
    output wire level_out,
    output wire rise_out
);
    reg meta_q;
    reg sync_q;
    reg prev_q;

    // The first stage feeds only the second stage, never logic.
    always @(posedge clk_in) begin
        if (rst_in) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_out = sync_q;
    assign rise_out = sync_q & ~prev_q;
endmodule // edge_sync

// File: external_mii_port_select.v
// External MII data port and management port pin control, on the system clock.
// Notes on behaviour
// RL1: PHY supplies transmit and receive clocks, 25 MHz or 2.5 MHz.
// RL2: Transmit nibble is forced to zero while the internal PHY is selected.
// RL3: Transmit enable only with valid nibble; zero while internal PHY selected.
// RL4: PHY raises receive error for an error anywhere in the current frame.
// RL5: PHY raises collision whenever it sees a collision on the medium.
// RL6: PHY raises receive valid while decoded nibbles are on receive data.
// RL7: PHY passes received data over a four-bit receive data bus.
// RL8: PHY drives carrier sense when it detects a carrier.
// RL9: Select set makes the management data pin the bidirectional serial line.
// RL10: Management data pin is sampled as an external-PHY-present strap.
// RL11: Management clock follows the MAC when selected, else driven low.
// RL12: Select clear places the management data pin in high impedance.
// RL13: Receive sampled on receive clock rise; transmit updated on transmit clock rise.
`include "mii_port_map.vh"
module external_mii_port_select #(
    parameter NIB_W = `NIBBLE_W,
    parameter STRAP_DELAY = `STRAP_DELAY_CYCLES
) (
    // System clock and reset
    input wire clk_in,
    input wire rst_in,
    // Configuration
    input wire ext_phy_select_in,
    input wire mgmt_port_select_in,
    // MAC transmit side
    input wire [NIB_W-1:0] mac_txd_in,
    input wire mac_tx_en_in,
    output reg mac_tx_strobe_out,
    // MAC receive side
    output reg [NIB_W-1:0] mac_rxd_out,
    output reg mac_rx_dv_out,
    output reg mac_rx_er_out,
    output reg mac_rx_strobe_out,
    output reg mac_col_out,
    output reg mac_crs_out,
    // MAC management side
    input wire mac_mdc_in,
    input wire mac_mdio_out_in,
    input wire mac_mdio_oe_in,
    output reg mac_mdio_in_out,
    output reg ext_phy_present_strap_out,
    // MII pins from the PHY
    input wire tx_clk_in,
    input wire rx_clk_in,
    input wire [NIB_W-1:0] rxd_in,
    input wire rx_dv_in,
    input wire rx_er_in,
    input wire col_in,
    input wire crs_in,
    // MII pins to the PHY
    output reg [NIB_W-1:0] txd_out,
    output reg tx_en_out,
    // Management pins, output enable low while driving
    output reg mdc_out,
    input wire mdio_in,
    output reg mdio_out,
    output reg mdio_oe_n_out
);
    wire tx_rise;
    wire rx_rise;
    wire [NIB_W-1:0] rxd_s;
    wire rx_dv_s;
    wire rx_er_s;
    wire col_s;
    wire crs_s;
    wire mdio_s;
    reg [NIB_W-1:0] txd_d;
    reg tx_en_d;
    reg [3:0] strap_cnt_q;
    reg [1:0] strap_state_q;

    // Strap sequencer: wait out the synchroniser flush, take the pin once, then hold.
    localparam [1:0] STRAP_WAIT = 2'h0;
    localparam [1:0] STRAP_HOLD = 2'h1;

    // Link clocks are sampled on the system clock; 100 MHz covers both rates.
    edge_sync u_tx_clk (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .async_in(tx_clk_in),
        .level_out(),
        .rise_out(tx_rise)
    ); // see RL1

    edge_sync u_rx_clk (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .async_in(rx_clk_in),
        .level_out(),
        .rise_out(rx_rise)
    ); // see RL1

    // Receive-side and management pins get their own two-flop stages.
    // Each bit resolves on its own, which is safe only because the link holds data
    // steady for several system clock cycles either side of the receive clock rise.
    genvar i;
    generate
        for (i = 0; i < NIB_W + 5; i = i + 1) begin : g_sync
            wire pin;
            wire lvl;
            if (i < NIB_W) begin : g_d
                assign pin = rxd_in[i];
                assign rxd_s[i] = lvl;
            end else if (i == NIB_W) begin : g_dv
                assign pin = rx_dv_in;
                assign rx_dv_s = lvl;
            end else if (i == NIB_W + 1) begin : g_er
                assign pin = rx_er_in;
                assign rx_er_s = lvl;
            end else if (i == NIB_W + 2) begin : g_col
                assign pin = col_in;
                assign col_s = lvl;
            end else if (i == NIB_W + 3) begin : g_crs
                assign pin = crs_in;
                assign crs_s = lvl;
            end else begin : g_md
                assign pin = mdio_in;
                assign mdio_s = lvl;
            end
            edge_sync u_s (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .async_in(pin),
                .level_out(lvl),
                .rise_out()
            );
        end
    endgenerate

    // Transmit pins change only on a transmit clock rise, or to zero on the system clock after a deselect.
    // After a reselect the pins stay at zero until the next rise, so a nibble
    // latched before the deselect is never replayed.
    always @* begin
        txd_d = txd_out;
        tx_en_d = tx_en_out;
        if (ext_phy_select_in != `SEL_EXTERNAL) begin
            txd_d = {NIB_W{1'b0}}; // see RL2
            tx_en_d = 1'b0; // see RL3
        end else if (tx_rise) begin
            tx_en_d = mac_tx_en_in; // see RL3, RL13
            txd_d = mac_tx_en_in ? mac_txd_in : {NIB_W{1'b0}}; // see RL13
        end
    end

    always @(posedge clk_in) begin
        if (rst_in) begin
            txd_out <= `NIBBLE_IDLE;
            tx_en_out <= 1'b0;
            mac_tx_strobe_out <= 1'b0;
            mac_rxd_out <= `NIBBLE_IDLE;
            mac_rx_dv_out <= 1'b0;
            mac_rx_er_out <= 1'b0;
            mac_rx_strobe_out <= 1'b0;
            mac_col_out <= 1'b0;
            mac_crs_out <= 1'b0;
        end else begin
            txd_out <= txd_d;
            tx_en_out <= tx_en_d;
            mac_tx_strobe_out <= tx_rise & ext_phy_select_in;
            mac_rx_strobe_out <= rx_rise;
            // The synchronisers delay data and clock alike, so capture stays aligned.
            if (rx_rise) begin
                mac_rxd_out <= rxd_s; // see RL7, RL13
                mac_rx_dv_out <= rx_dv_s; // see RL6, RL13
                mac_rx_er_out <= rx_er_s; // see RL4, RL13
            end
            // Collision and carrier sense pass as plain levels, not gated by the receive
            // clock, so the MAC sees them between receive edges and outside frames.
            mac_col_out <= col_s; // see RL5
            mac_crs_out <= crs_s; // see RL8
        end
    end

    // Management pins; MDC is slow enough that one cycle of skew is harmless.
    always @(posedge clk_in) begin
        if (rst_in) begin
            mdc_out <= 1'b0;
            mdio_out <= 1'b0;
            mdio_oe_n_out <= 1'b1;
            mac_mdio_in_out <= 1'b0;
        end else if (mgmt_port_select_in == `SEL_EXTERNAL) begin
            mdc_out <= mac_mdc_in; // see RL11
            mdio_out <= mac_mdio_out_in; // see RL9
            mdio_oe_n_out <= ~mac_mdio_oe_in; // see RL9
            mac_mdio_in_out <= mdio_s; // see RL9
        end else begin
            mdc_out <= 1'b0; // see RL11
            mdio_out <= 1'b0;
            mdio_oe_n_out <= 1'b1; // see RL12
            mac_mdio_in_out <= 1'b0;
        end
    end

    // Strap is caught once, a few cycles after reset release, with no check that the pin is undriven.
    // A MAC that drives the data pin in those first cycles would spoil the strap,
    // so the management port is best left deselected until the strap is taken.
    always @(posedge clk_in) begin
        if (rst_in) begin
            strap_state_q <= STRAP_WAIT;
            strap_cnt_q <= 4'h0;
            ext_phy_present_strap_out <= 1'b0;
        end else begin
            case (strap_state_q)
                STRAP_WAIT: begin
                    if (strap_cnt_q == STRAP_DELAY[3:0]) begin
                        strap_state_q <= STRAP_HOLD;
                        ext_phy_present_strap_out <= mdio_s; // see RL10
                    end else begin
                        strap_cnt_q <= strap_cnt_q + 4'h1;
                    end
                end
                STRAP_HOLD: begin
                    strap_state_q <= STRAP_HOLD;
                end
                default: begin
                    strap_state_q <= STRAP_WAIT;
                end
            endcase
        end
    end
endmodule // external_mii_port_select

// File: external_mii_port_select_tb.sv
// Self-checking bench for the external MII port select block.
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; $display("ERROR at %0t: got %h expected %h", $time, a, b); end end
module external_mii_port_select_tb;
    timeunit 1ns; timeprecision 100ps;
    logic clk_in = 0, rst_in = 1, ext_phy_select_in = 1, mgmt_port_select_in = 0;
    logic mac_tx_en_in = 0, mac_mdc_in = 0, mac_mdio_out_in = 0, mac_mdio_oe_in = 0;
    logic strap = 1, upd = 0, sel_q = 0, exp_dv, exp_er, exp_col, exp_crs;
    logic [2:0] md_hist = 3'h0;
    logic [3:0] mac_txd_in = 4'h0, mac_rxd_out, rxd_in, txd_out, exp_rxd;
    logic mac_tx_strobe_out, mac_rx_dv_out, mac_rx_er_out, mac_rx_strobe_out, mac_col_out;
    logic mac_crs_out, mac_mdio_in_out, ext_phy_present_strap_out, tx_clk_in, rx_clk_in;
    logic rx_dv_in, rx_er_in, col_in, crs_in, tx_en_out, mdc_out, mdio_in, mdio_out, mdio_oe_n_out;
    int miscompares = 0, comparisons = 0, seed = 32'ha9fa;
    phy_model phy (.strap_in(strap), .mdio_out_in(mdio_out), .mdio_oe_n_in(mdio_oe_n_out),
        .tx_clk_out(tx_clk_in), .rx_clk_out(rx_clk_in), .rx_dv_out(rx_dv_in), .rx_er_out(rx_er_in),
        .col_out(col_in), .crs_out(crs_in), .mdio_pin_out(mdio_in), .rxd_out(rxd_in));
    external_mii_port_select dut (.*);
    initial forever #5 clk_in = ~clk_in;
    function automatic logic [4:0] tx_exp(logic sel, logic en, logic [3:0] d);
        return (sel && en) ? {1'b1, d} : 5'h00;
    endfunction
    always @(posedge rx_clk_in) begin
        {exp_er, exp_dv, exp_rxd} <= {rx_er_in, rx_dv_in, rxd_in};
        {exp_col, exp_crs} <= {col_in, crs_in};
    end
    // Select as seen at the launch edge, and the recent history of the management pin.
    always @(posedge clk_in) begin
        sel_q <= ext_phy_select_in;
        md_hist <= {md_hist[1:0], mdio_in};
    end
    // Checks sit on the falling edge, clear of the drivers that act just after the rise.
    always @(negedge clk_in) if (!rst_in) begin
        if (mac_rx_strobe_out) `CHK({mac_rx_er_out, mac_rx_dv_out, mac_rxd_out}, {exp_er, exp_dv, exp_rxd})
        if (mac_rx_strobe_out) `CHK({mac_col_out, mac_crs_out}, {exp_col, exp_crs})
        if (mac_tx_strobe_out) begin
            `CHK({tx_en_out, txd_out}, tx_exp(sel_q, mac_tx_en_in, mac_txd_in))
            upd = 1;
        end
    end
    always @(posedge clk_in) begin
        #1;
        if (upd) {mac_tx_en_in, mac_txd_in} = 5'($random(seed));
        upd = 0;
    end
    task automatic do_reset(input logic s);
        mgmt_port_select_in = 0;
        strap = s;
        rst_in = 1;
        repeat (5) @(posedge clk_in);
        #1 rst_in = 0;
        repeat (10) @(posedge clk_in);
        #1 `CHK(ext_phy_present_strap_out, s)
        $display("reset test done");
    endtask
    task automatic traffic(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            #1;
            if (i > 0) `CHK({mdc_out, mdio_oe_n_out, mdio_out}, mgmt_port_select_in ? {mac_mdc_in, !mac_mdio_oe_in, mac_mdio_out_in} : 3'h2)
            if (i > 0 && !ext_phy_select_in) `CHK({tx_en_out, txd_out}, 5'h00)
            if (i > 0) `CHK(mac_mdio_in_out, mgmt_port_select_in & md_hist[2])
            {mac_mdc_in, mac_mdio_out_in, mac_mdio_oe_in} = 3'($random(seed));
            if (i % 16 == 0) mgmt_port_select_in = 1'($random(seed));
            if (i % 400 == 399) ext_phy_select_in = ~ext_phy_select_in;
        end
        $display("traffic test done");
    endtask
    task automatic give_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        do_reset(1'b1);
        traffic(3000);
        do_reset(1'b0);
        traffic(1200);
        give_verdict();
    end
    initial begin
        #200000;
        miscompares++;
        give_verdict();
    end
endmodule // external_mii_port_select_tb

// File: mii_port_checker.sv
// Checker for the pin rules of the external MII port select block.
module mii_port_checker #(parameter NIB_W = 4) (
    input wire clk_in, rst_in, ext_phy_select_in, mgmt_port_select_in, mac_tx_en_in,
    input wire [NIB_W-1:0] mac_txd_in, mac_rxd_out, txd_out,
    input wire mac_tx_strobe_out, mac_rx_strobe_out, tx_en_out, mdc_out, mdio_out,
    input wire mac_mdc_in, mac_mdio_out_in, mac_mdio_oe_in, mdio_oe_n_out
);
    timeunit 1ns; timeprecision 100ps;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_tx_parked: assert property (!ext_phy_select_in |=> txd_out == '0 && !tx_en_out)
        else $error("tx pins not parked");
    a_tx_idle: assert property (!tx_en_out |-> txd_out == '0)
        else $error("tx data without enable");
    a_tx_capture: assert property (mac_tx_strobe_out && $past(ext_phy_select_in) |->
        tx_en_out == $past(mac_tx_en_in) && txd_out == ($past(mac_tx_en_in) ? $past(mac_txd_in) : '0))
        else $error("tx nibble not captured");
    a_tx_on_strobe: assert property ($changed({tx_en_out, txd_out}) |->
        mac_tx_strobe_out || $past(!ext_phy_select_in)) else $error("tx changed off clock");
    a_rx_on_strobe: assert property ($changed(mac_rxd_out) |-> mac_rx_strobe_out)
        else $error("rx changed off clock");
    a_mdc_parked: assert property (!mgmt_port_select_in |=> !mdc_out)
        else $error("mdc not low");
    a_mdc_follow: assert property (mgmt_port_select_in |=> mdc_out == $past(mac_mdc_in))
        else $error("mdc not passed");
    a_mdio_float: assert property (!mgmt_port_select_in |=> mdio_oe_n_out)
        else $error("mdio driven while parked");
    a_mdio_drive: assert property (mgmt_port_select_in |=>
        mdio_oe_n_out != $past(mac_mdio_oe_in) && mdio_out == $past(mac_mdio_out_in))
        else $error("mdio not passed");
    c_tx: cover property (mac_tx_strobe_out && tx_en_out);
    c_rx: cover property (mac_rx_strobe_out);
    c_sel: cover property (mgmt_port_select_in ##1 !mgmt_port_select_in);
endmodule // mii_port_checker

bind external_mii_port_select mii_port_checker #(.NIB_W(NIB_W)) chk (
    .clk_in(clk_in), .rst_in(rst_in), .ext_phy_select_in(ext_phy_select_in),
    .mgmt_port_select_in(mgmt_port_select_in), .mac_tx_en_in(mac_tx_en_in),
    .mac_txd_in(mac_txd_in), .mac_rxd_out(mac_rxd_out), .txd_out(txd_out),
    .mac_tx_strobe_out(mac_tx_strobe_out), .mac_rx_strobe_out(mac_rx_strobe_out),
    .tx_en_out(tx_en_out), .mdc_out(mdc_out), .mdio_out(mdio_out), .mac_mdc_in(mac_mdc_in),
    .mac_mdio_out_in(mac_mdio_out_in), .mac_mdio_oe_in(mac_mdio_oe_in),
    .mdio_oe_n_out(mdio_oe_n_out));

// File: mii_port_map.vh
// Constants for the external MII data port and management port select block.
`ifndef MII_PORT_MAP_VH
`define MII_PORT_MAP_VH
`define NIBBLE_W 4
`define NIBBLE_IDLE 4'h0
`define SYS_CLK_MHZ 100
`define LINK_CLK_FAST_MHZ 25
`define LINK_CLK_FAST_KHZ 25000
`define LINK_CLK_SLOW_KHZ 2500
`define SEL_EXTERNAL 1'b1
`define SEL_INTERNAL 1'b0
`define STRAP_DELAY_CYCLES 4
`endif

// File: phy_model.sv
// Behavioural external PHY with free-running link clocks and a strap on the data pin.
module phy_model (
    input wire logic strap_in, mdio_out_in, mdio_oe_n_in,
    output logic tx_clk_out, rx_clk_out, rx_dv_out, rx_er_out, col_out, crs_out, mdio_pin_out,
    output logic [3:0] rxd_out
);
    timeunit 1ns; timeprecision 100ps;
    int seed = 32'ha9fa;
    logic v;
    initial begin
        {tx_clk_out, rx_clk_out, rx_dv_out, rx_er_out, col_out, crs_out, rxd_out} = '0;
        forever #62.5 tx_clk_out = ~tx_clk_out;
    end
    // Offset so the receive clock shares no phase with the transmit clock or the system clock.
    initial #17 forever #62.5 rx_clk_out = ~rx_clk_out;
    always @(negedge rx_clk_out) begin
        v = ($random(seed) & 7) != 0;
        rx_dv_out <= v;
        rxd_out <= v ? 4'($random(seed)) : ~rxd_out;
        rx_er_out <= v && ($random(seed) & 15) == 0;
        crs_out <= v;
        col_out <= v && ($random(seed) & 31) == 0;
    end
    // The strap resistor sets the level whenever the device releases the pin.
    assign mdio_pin_out = mdio_oe_n_in ? strap_in : mdio_out_in;
endmodule // phy_model
